// [gpiom_pin_partner.sv]
// Model of the devices and pull-ups on the port pins
module gpiom_pin_partner (
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	output logic [15:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Port drive first, then the outside device, else the pull-up
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en);
endmodule // gpiom_pin_partner

// [gpiom_pinmux.sv]
// Per-pin output ownership multiplexer with open-drain conversion
module gpiom_pinmux (
	input wire logic dir_in,
	input wire logic latch_val,
	input wire logic od_sel,
	input wire logic per_a_en,
	input wire logic per_a_out,
	input wire logic per_a_oe,
	input wire logic per_b_en,
	input wire logic per_b_out,
	input wire logic per_b_oe,
	output logic pin_val,
	output logic pin_drive
);
	// ==========================================================================
	// Ownership and driver control
	logic data_sel;
	logic drive_sel;

	always_comb begin
		if (per_a_en) begin
			data_sel = per_a_out;
			drive_sel = per_a_oe;
		end else if (per_b_en) begin
			data_sel = per_b_out;
			drive_sel = per_b_oe;
		end else begin
			data_sel = latch_val;
			drive_sel = !dir_in;
		end
		if (od_sel) begin
			pin_val = 1'b0;
			pin_drive = drive_sel && !data_sel;
		end else begin
			pin_val = data_sel;
			pin_drive = drive_sel;
		end
	end
endmodule // gpiom_pinmux

// [gpiom_pkg.sv]
// Package of register map, reset values and widths for the general I/O port
package gpiom_pkg;
	// ==========================================================================
	// Register byte addresses
	localparam logic [11:0] GPIOM_DIR_ADDR = 12'h000;
	localparam logic [11:0] GPIOM_LEVEL_ADDR = 12'h004;
	localparam logic [11:0] GPIOM_LATCH_ADDR = 12'h008;
	localparam logic [11:0] GPIOM_ODSEL_ADDR = 12'h00C;
	localparam logic [11:0] GPIOM_ANSEL_ADDR = 12'h010;
	localparam logic [11:0] GPIOM_PEREN_A_ADDR = 12'h014;
	localparam logic [11:0] GPIOM_PEREN_B_ADDR = 12'h018;
	localparam logic [11:0] GPIOM_LVLSET_ADDR = 12'h01C;
	localparam logic [11:0] GPIOM_LVLCLR_ADDR = 12'h020;
	localparam int GPIOM_ADDR_W = 12;
	// ==========================================================================
	// Widths and reset values
	localparam int GPIOM_PINS = 16;
	localparam int GPIOM_DATA_W = 32;
	localparam logic [31:0] GPIOM_DIR_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] GPIOM_ZERO = 32'h00000000;
	localparam logic [31:0] GPIOM_ANSEL_RESET = 32'h00000000;
	localparam int GPIOM_SYNC_STAGES = 2;
	// ==========================================================================
	// Bus access kinds
	typedef enum logic [1:0] {
		GPIOM_ACC_NONE,
		GPIOM_ACC_READ,
		GPIOM_ACC_WRITE
	} gpiom_acc_e;
endpackage

// [gpiom_port.sv]
// General I/O port with APB registers, peripheral ownership and open-drain
// ==========================================================================
// Behaviour
// - Port holds direction, pin level, output latch and open-drain select registers.
// - Direction one makes pin an input; zero drives the latch value.
// - Every implemented direction bit resets to one so all pins start as inputs; unimplemented bits reset to zero.
// - Reading pin level returns the pin state, not the latch.
// - Writing pin level stores data into the output latch.
// - Reading output latch returns latch contents whatever the pins show.
// - Writing output latch updates the same latch as pin level writes.
// - Bit set or clear on pin level copies sampled pin levels into latch.
// - Unimplemented bits are disabled and read as zero.
// - Open-drain select bit makes its own pin open-drain.
// - Open-drain applies to latch-driven and peripheral-driven outputs alike.
// - Enabled peripheral disables port driver; pin stays readable.
// - Multiplexers hand output data and control to the enabled peripheral.
// - Peripheral A outranks peripheral B when both are enabled.
module gpiom_port
	import gpiom_pkg::*;
#(
	parameter int PINS = GPIOM_PINS,
	parameter logic [GPIOM_PINS-1:0] IMPL_MASK = 16'hFFFF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [GPIOM_ADDR_W-1:0] paddr,
	input wire logic [GPIOM_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [GPIOM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] analog_select,
	output logic [PINS-1:0] per_a_in,
	output logic [PINS-1:0] per_b_in,
	input wire logic [PINS-1:0] per_a_hw_en,
	input wire logic [PINS-1:0] per_a_out,
	input wire logic [PINS-1:0] per_a_oe,
	input wire logic [PINS-1:0] per_b_hw_en,
	input wire logic [PINS-1:0] per_b_out,
	input wire logic [PINS-1:0] per_b_oe
);
	// ==========================================================================
	// Elaboration check
	if (PINS < 1 || PINS > GPIOM_PINS) begin : g_bad_pins
		$error("gpiom_port: PINS must be 1 to 16");
	end

	localparam logic [PINS-1:0] MASK = IMPL_MASK[PINS-1:0];

	// ==========================================================================
	// Reset release
	logic rst_s1;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// ==========================================================================
	// Pin input synchroniser
	logic [PINS-1:0] pin_sync;
	gpiom_sync #(
		.WIDTH(PINS)
	) u_sync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ==========================================================================
	// Register state
	logic [PINS-1:0] pin_direction;
	logic [PINS-1:0] output_latch;
	logic [PINS-1:0] open_drain_select;
	logic [PINS-1:0] ansel;
	logic [PINS-1:0] per_a_en_reg;
	logic [PINS-1:0] per_b_en_reg;
	logic [PINS-1:0] next_pin_direction;
	logic [PINS-1:0] next_output_latch;
	logic [PINS-1:0] next_open_drain_select;
	logic [PINS-1:0] next_ansel;
	logic [PINS-1:0] next_per_a_en;
	logic [PINS-1:0] next_per_b_en;
	logic [GPIOM_DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	gpiom_acc_e acc;

	// Merge byte strobes onto a register value
	function automatic logic [PINS-1:0] strobed(input logic [PINS-1:0] old_val,
			input logic [GPIOM_DATA_W-1:0] wdata, input logic [3:0] strb);
		logic [GPIOM_DATA_W-1:0] wide;
		integer i;
		wide = GPIOM_ZERO;
		wide[PINS-1:0] = old_val;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i]) begin
				wide[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return wide[PINS-1:0] & MASK;
	endfunction

	// Zero-extend a pin vector to the bus width
	function automatic logic [GPIOM_DATA_W-1:0] widen(input logic [PINS-1:0] v);
		logic [GPIOM_DATA_W-1:0] w;
		w = GPIOM_ZERO;
		w[PINS-1:0] = v & MASK;
		return w;
	endfunction

	// ==========================================================================
	// APB access decode
	always_comb begin
		if (psel && penable && !pready) begin
			acc = pwrite ? GPIOM_ACC_WRITE : GPIOM_ACC_READ;
		end else begin
			acc = GPIOM_ACC_NONE;
		end
	end

	// ==========================================================================
	// Register next state
	always_comb begin
		next_pin_direction = pin_direction;
		next_output_latch = output_latch;
		next_open_drain_select = open_drain_select;
		next_ansel = ansel;
		next_per_a_en = per_a_en_reg;
		next_per_b_en = per_b_en_reg;
		next_prdata = GPIOM_ZERO;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		unique case (acc)
			GPIOM_ACC_NONE: begin
			end
			GPIOM_ACC_WRITE: begin
				next_pready = 1'b1;
				unique case (paddr)
					GPIOM_DIR_ADDR: next_pin_direction = strobed(pin_direction, pwdata, pstrb);
					GPIOM_LEVEL_ADDR: next_output_latch = strobed(output_latch, pwdata, pstrb);
					GPIOM_LATCH_ADDR: next_output_latch = strobed(output_latch, pwdata, pstrb);
					GPIOM_ODSEL_ADDR: next_open_drain_select = strobed(open_drain_select, pwdata,
						pstrb);
					GPIOM_ANSEL_ADDR: next_ansel = strobed(ansel, pwdata, pstrb);
					GPIOM_PEREN_A_ADDR: next_per_a_en = strobed(per_a_en_reg, pwdata, pstrb);
					GPIOM_PEREN_B_ADDR: next_per_b_en = strobed(per_b_en_reg, pwdata, pstrb);
					GPIOM_LVLSET_ADDR: next_output_latch = (pin_sync | pwdata[PINS-1:0]) & MASK;
					GPIOM_LVLCLR_ADDR: next_output_latch = (pin_sync & ~pwdata[PINS-1:0]) & MASK;
					default: next_pslverr = 1'b1;
				endcase
			end
			GPIOM_ACC_READ: begin
				next_pready = 1'b1;
				unique case (paddr)
					GPIOM_DIR_ADDR: next_prdata = widen(pin_direction);
					GPIOM_LEVEL_ADDR: next_prdata = widen(pin_sync);
					GPIOM_LATCH_ADDR: next_prdata = widen(output_latch);
					GPIOM_ODSEL_ADDR: next_prdata = widen(open_drain_select);
					GPIOM_ANSEL_ADDR: next_prdata = widen(ansel);
					GPIOM_PEREN_A_ADDR: next_prdata = widen(per_a_en_reg);
					GPIOM_PEREN_B_ADDR: next_prdata = widen(per_b_en_reg);
					GPIOM_LVLSET_ADDR: next_prdata = widen(pin_sync);
					GPIOM_LVLCLR_ADDR: next_prdata = widen(pin_sync);
					default: next_pslverr = 1'b1;
				endcase
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_direction <= GPIOM_DIR_RESET[PINS-1:0] & MASK;
			output_latch <= '0;
			open_drain_select <= '0;
			ansel <= GPIOM_ANSEL_RESET[PINS-1:0];
			per_a_en_reg <= '0;
			per_b_en_reg <= '0;
			prdata <= GPIOM_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pin_direction <= next_pin_direction;
			output_latch <= next_output_latch;
			open_drain_select <= next_open_drain_select;
			ansel <= next_ansel;
			per_a_en_reg <= next_per_a_en;
			per_b_en_reg <= next_per_b_en;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================================
	// Pin output path
	logic [PINS-1:0] mux_val;
	logic [PINS-1:0] mux_drive;
	logic [PINS-1:0] next_pin_out;
	logic [PINS-1:0] next_pin_oe;

	for (genvar g = 0; g < PINS; g++) begin : g_pin
		gpiom_pinmux u_mux (
			.dir_in(pin_direction[g]),
			.latch_val(output_latch[g]),
			.od_sel(open_drain_select[g]),
			.per_a_en(per_a_en_reg[g] && per_a_hw_en[g]),
			.per_a_out(per_a_out[g]),
			.per_a_oe(per_a_oe[g]),
			.per_b_en(per_b_en_reg[g] && per_b_hw_en[g]),
			.per_b_out(per_b_out[g]),
			.per_b_oe(per_b_oe[g]),
			.pin_val(mux_val[g]),
			.pin_drive(mux_drive[g])
		);
	end

	always_comb begin
		next_pin_out = mux_val & MASK;
		next_pin_oe = mux_drive & MASK;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= '0;
			pin_oe <= '0;
			analog_select <= '0;
			per_a_in <= '0;
			per_b_in <= '0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			analog_select <= ansel;
			per_a_in <= pin_sync;
			per_b_in <= pin_sync;
		end
	end
endmodule // gpiom_port

// [gpiom_port_checker.sv]
// Port checker for the general I/O port
module gpiom_port_checker
	import gpiom_pkg::*;
#(
	parameter int PINS = GPIOM_PINS
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [GPIOM_DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] per_a_in,
	input wire logic [PINS-1:0] per_b_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] run_cnt;
	logic [3:0] next_run_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================================
	// Cycles since reset release
	always_comb next_run_cnt = (run_cnt == 4'hF) ? run_cnt : run_cnt + 4'h1;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			run_cnt <= 4'h0;
		else
			run_cnt <= next_run_cnt;
	end
	// ==========================================================================
	// Properties
	property p_quiet; run_cnt < 4'h3 |-> pin_oe == '0 && !pready; endproperty
	property p_wait; psel && penable && !pready |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_cause; pready |-> $past(psel) && $past(penable); endproperty
	property p_err; pslverr |-> pready && prdata == '0; endproperty
	property p_idle; !pready |-> prdata == '0; endproperty
	property p_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
	property p_sync;
		$stable(pin_in)[*5] ##0 run_cnt == 4'hF |-> per_a_in == pin_in && per_b_in == pin_in;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs active after reset");
	a_wait: assert property (p_wait) else $error("no answer after one wait");
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	a_cause: assert property (p_cause) else $error("pready without access");
	a_err: assert property (p_err) else $error("error answer malformed");
	a_idle: assert property (p_idle) else $error("read data outside answer");
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	a_sync: assert property (p_sync) else $error("pin level not passed on");
	c_err: cover property (pslverr);
	c_read: cover property (pready && prdata != '0);
	c_drive: cover property (pin_oe != '0);
endmodule // gpiom_port_checker

// [gpiom_sync.sv]
// Two flip-flop synchroniser for a vector of asynchronous inputs
module gpiom_sync
	import gpiom_pkg::*;
#(
	parameter int WIDTH = GPIOM_PINS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ==========================================================================
	// Stages
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule // gpiom_sync

// [testbench.sv]
// Testbench for the general I/O port
module testbench import gpiom_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv;
	logic [15:0] e_en = '0, e_val = '0, a_en = '0, a_out = '0, a_oe = '0;
	logic [15:0] b_en = '0, b_out = '0, b_oe = '0, pin_in, pin_out, pin_oe;
	logic pready, pslverr, ev;
	logic [15:0] asel;
	logic [3:0] strb = 4'hF;
	int bad_count = 0, samples_checked = 0;
	always #20 sys_clk = ~sys_clk;
	gpiom_port dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .analog_select(asel), .per_a_in(), .per_b_in(), .per_a_hw_en(a_en),
		.per_a_out(a_out), .per_a_oe(a_oe), .per_b_hw_en(b_en), .per_b_out(b_out),
		.per_b_oe(b_oe));
	gpiom_pin_partner ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(e_en),
		.ext_val(e_val), .pin_level(pin_in));
	// ==========================================================================
	// Shared tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50)
			bad_count++;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(a, 1'b0, '0);
		check(nm, rv, x);
	endtask
	task automatic pins(input logic [15:0] oe, input logic [15:0] out);
		repeat (4) @(posedge sys_clk);
		check("pin_oe", {16'h0, pin_oe}, {16'h0, oe});
		check("pin_out", {16'h0, pin_out & oe}, {16'h0, out});
	endtask
	// ==========================================================================
	// Scenarios
	task automatic t_reset;
		pins(16'h0000, 16'h0000);
		rd(GPIOM_DIR_ADDR, 32'h0000FFFF, "dir");
		rd(GPIOM_LATCH_ADDR, 32'h0, "latch");
		wr(12'h040, 32'hFFFFFFFF);
		check("slverr", {31'h0, ev}, 32'h1);
		rd(12'h040, 32'h0, "unmapped");
	endtask
	task automatic t_regs;
		rd(GPIOM_LEVEL_ADDR, 32'h0000FFFF, "level");
		wr(GPIOM_ODSEL_ADDR, 32'hFFFF5AC3);
		rd(GPIOM_ODSEL_ADDR, 32'h00005AC3, "odsel");
		wr(GPIOM_DIR_ADDR, 32'hFFFF5AC3);
		rd(GPIOM_DIR_ADDR, 32'h00005AC3, "dir");
		strb <= 4'h1;
		wr(GPIOM_ODSEL_ADDR, 32'h0000FFFF);
		strb <= 4'hF;
		rd(GPIOM_ODSEL_ADDR, 32'h00005AFF, "odsel_strobe");
		wr(GPIOM_ODSEL_ADDR, 32'h0);
	endtask
	task automatic t_latch;
		wr(GPIOM_ANSEL_ADDR, 32'h8001);
		repeat (2) @(posedge sys_clk);
		check("analog_select", {16'h0, asel}, 32'h8001);
		wr(GPIOM_ANSEL_ADDR, 32'h0);
		wr(GPIOM_DIR_ADDR, 32'h0);
		wr(GPIOM_LEVEL_ADDR, 32'h1234);
		pins(16'hFFFF, 16'h1234);
		rd(GPIOM_LEVEL_ADDR, 32'h1234, "level");
		wr(GPIOM_DIR_ADDR, 32'hFFFF);
		e_en <= 16'hFFFF;
		e_val <= 16'h0F0F;
		pins(16'h0000, 16'h0000);
		rd(GPIOM_LEVEL_ADDR, 32'h0F0F, "level");
		rd(GPIOM_LATCH_ADDR, 32'h1234, "latch");
		wr(GPIOM_LATCH_ADDR, 32'h00FF);
		rd(GPIOM_LATCH_ADDR, 32'h00FF, "latch");
		wr(GPIOM_LVLSET_ADDR, 32'h1);
		rd(GPIOM_LATCH_ADDR, 32'h0F0F, "set");
		wr(GPIOM_LVLCLR_ADDR, 32'h0F00);
		rd(GPIOM_LATCH_ADDR, 32'h000F, "clear");
		e_en <= 16'h0000;
	endtask
	task automatic t_odrain;
		wr(GPIOM_ODSEL_ADDR, 32'h00FF);
		wr(GPIOM_LATCH_ADDR, 32'hA0F0);
		wr(GPIOM_DIR_ADDR, 32'h0);
		pins(16'hFF0F, 16'hA000);
		rd(GPIOM_LEVEL_ADDR, 32'hA0F0, "level");
		wr(GPIOM_DIR_ADDR, 32'hFFFF);
		wr(GPIOM_ODSEL_ADDR, 32'h0001);
	endtask
	task automatic t_periph;
		a_en <= 16'hFFFF;
		b_en <= 16'hFFFF;
		a_out <= 16'h0005;
		a_oe <= 16'h000F;
		b_out <= 16'h00AA;
		b_oe <= 16'h00FF;
		wr(GPIOM_PEREN_A_ADDR, 32'h000F);
		wr(GPIOM_PEREN_B_ADDR, 32'h00FF);
		pins(16'h00FE, 16'h00A4);
		rd(GPIOM_LEVEL_ADDR, 32'hFFA5, "level");
		wr(GPIOM_PEREN_A_ADDR, 32'h0);
		pins(16'h00FF, 16'h00AA);
	endtask
	task automatic t_rerun;
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		pins(16'h0000, 16'h0000);
		rd(GPIOM_DIR_ADDR, 32'h0000FFFF, "dir");
		rd(GPIOM_LATCH_ADDR, 32'h0, "latch");
		rd(GPIOM_PEREN_B_ADDR, 32'h0, "per_b_en");
	endtask
	// ==========================================================================
	// Main sequence and watchdog
	initial begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset;
		t_regs;
		t_latch;
		t_odrain;
		t_periph;
		t_rerun;
		report_and_stop;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		bad_count++;
		report_and_stop;
	end
endmodule // testbench
bind gpiom_port gpiom_port_checker #(.PINS(PINS)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pin_in(pin_in), .pin_oe(pin_oe), .per_a_in(per_a_in), .per_b_in(per_b_in));
